// [sled_blink.sv]
// Purpose : one indicator channel: function select, blink timing, polarity
// Assumes : on/off times in units of the slow tick
// Notes   : drive level is the lit state after polarity is applied
module sled_blink #(
    parameter int ACT_W = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             tick,
    input  wire logic             enable,
    input  wire logic             blink_mode,
    input  wire logic [3:0]       func_sel,
    input  wire logic [7:0]       on_time,
    input  wire logic [7:0]       off_time,
    input  wire logic             active_high,
    input  wire logic             link_up,
    input  wire logic             tx_act,
    input  wire logic             rx_act,
    input  wire logic [ACT_W-1:0] act_level,
    output logic                  lit,
    output logic                  drive
);

    logic       traffic;
    logic       steady;
    logic       blinks;
    logic       phase_r;
    logic [7:0] cnt_r;
    logic [7:0] on_len;
    logic [7:0] off_len;
    logic       lit_nxt;

    assign traffic = tx_act | rx_act;

    // ****************************************************************
    // function decode
    // ****************************************************************
    always_comb begin
        steady = 1'b0;
        blinks = 1'b0;
        case (func_sel)
            sled_pkg::FUNC_LINK_AND_TRAFFIC: begin
                steady = link_up;
                blinks = link_up & traffic;
            end
            sled_pkg::FUNC_TRAFFIC_ONLY: blinks = traffic;
            sled_pkg::FUNC_LINK_ONLY:    steady = link_up;
            sled_pkg::FUNC_TX_ONLY:      blinks = tx_act;
            sled_pkg::FUNC_RX_ONLY:      blinks = rx_act;
            sled_pkg::FUNC_ALWAYS_ON:    steady = 1'b1;
            default: begin
                // codes 7..10 steady-blink, mode 1 only
                if (func_sel >= sled_pkg::FUNC_M1_FIRST &&
                    func_sel <= sled_pkg::FUNC_M1_LAST && !blink_mode) begin
                    blinks = 1'b1;
                end
            end
        endcase
    end

    // ****************************************************************
    // blink duty: programmed (mode 1) or from activity level (mode 2)
    // ****************************************************************
    always_comb begin
        if (!blink_mode) begin
            on_len  = on_time;
            off_len = off_time;
        end else begin
            on_len  = 8'(act_level >> (ACT_W - 8 + 1)) + 8'h01;
            off_len = 8'h81 - on_len;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || !blinks) begin
            phase_r <= 1'b1;
            cnt_r   <= 8'h00;
        end else if (tick) begin
            if (cnt_r + 8'h01 >= (phase_r ? on_len : off_len)) begin
                cnt_r   <= 8'h00;
                phase_r <= ~phase_r;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end

    assign lit_nxt = enable & (blinks ? phase_r : steady);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            lit   <= 1'b0;
            drive <= 1'b0;
        end else begin
            lit   <= lit_nxt;
            drive <= active_high ? lit_nxt : ~lit_nxt;
        end
    end

endmodule : sled_blink

// [sled_led_model.sv]
// Purpose : indicator pins with their external loads
// Assumes : pin a pulled up, pin b pulled down while released
// Notes   : a released pin settles to its pull level, never the last drive
module sled_led_model (
    input  wire logic a_out,
    input  wire logic a_oe_n,
    input  wire logic b_out,
    input  wire logic b_oe_n,
    output logic      a_level,
    output logic      b_level
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // resolved pin levels
    // ****************************************************************
    assign a_level = a_oe_n ? 1'b1 : a_out;
    assign b_level = b_oe_n ? 1'b0 : b_out;

endmodule : sled_led_model

// [sled_pkg.sv]
// Purpose : constants for the status indicator driver
// Assumes : 32-bit AHB-Lite register access, one word per register
// Notes   : function codes and register layout shared by the design and bench files
package sled_pkg;

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [11:0] OFS_CONTROL  = 12'h000;
    localparam logic [11:0] OFS_POLARITY = 12'h004;
    localparam logic [11:0] OFS_ROUTE    = 12'h008;
    localparam logic [11:0] OFS_BLINK_A  = 12'h00C;
    localparam logic [11:0] OFS_BLINK_B  = 12'h010;
    localparam logic [11:0] OFS_STATUS   = 12'h014;

    // ****************************************************************
    // control register fields, a in [7:0], b in [15:8]
    // ****************************************************************
    localparam int FUNC_LSB   = 0;
    localparam int MODE_BIT   = 6;
    localparam int EN_BIT     = 7;
    localparam int B_SHIFT    = 8;
    localparam int FUNC_W     = 4;

    // ****************************************************************
    // function codes
    // ****************************************************************
    localparam logic [3:0] FUNC_LINK_AND_TRAFFIC = 4'h0;
    localparam logic [3:0] FUNC_TRAFFIC_ONLY     = 4'h1;
    localparam logic [3:0] FUNC_LINK_ONLY        = 4'h2;
    localparam logic [3:0] FUNC_TX_ONLY          = 4'h3;
    localparam logic [3:0] FUNC_RX_ONLY          = 4'h4;
    localparam logic [3:0] FUNC_ALWAYS_ON        = 4'h5;
    localparam logic [3:0] FUNC_ALWAYS_OFF       = 4'h6;
    localparam logic [3:0] FUNC_M1_FIRST         = 4'h7;
    localparam logic [3:0] FUNC_M1_LAST          = 4'hA;

    // ****************************************************************
    // polarity codes and reset values
    // ****************************************************************
    localparam logic [1:0] POL_AUTO = 2'h0;
    localparam logic [1:0] POL_HIGH = 2'h1;
    localparam logic [1:0] POL_LOW  = 2'h2;

    localparam logic [15:0] CONTROL_RST = 16'h0180;
    localparam logic [1:0]  ROUTE_OFF   = 2'h0;
    localparam logic [1:0]  ROUTE_ON    = 2'h1;
    localparam logic [15:0] BLINK_RST   = 16'h1010;
    localparam int          BLINK_UNIT  = 8;

endpackage : sled_pkg

// [sled_top.sv]
// Purpose : status indicator driver for a single-pair Ethernet PHY
// Assumes : AHB-Lite slave, zero wait states, OKAY responses only
// Notes   : pins are three-signal; enable low means the pin is driven
//
// Overview of operation
// - software selects each indicator's displayed activity
// - indicator b reaches pin only when routed
// - indicator a drives its pin once autosense is done
// - polarity auto, high, low; auto after reset
// - autosense samples pin level on the fourth clock after reset
// - active high: output high lights LED
// - active low: output low lights LED
// - function codes 7..10 only in mode 1
// - mode 1 duty follows blink time register
// - mode 2 duty follows activity level
// - after reset a enabled, b not routed
// - enable bit per indicator gates activity
// - blink mode bit per indicator, default mode 1
// - defaults: a link+traffic, b traffic only
module sled_top #(
    parameter int ACT_W    = 8,
    parameter int TICK_DIV = 40000
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    input  wire logic             link_up,
    input  wire logic             tx_act,
    input  wire logic             rx_act,
    input  wire logic [ACT_W-1:0] act_level,
    input  wire logic             indicator_out_a_in,
    output logic                  indicator_out_a_out,
    output logic                  indicator_out_a_oe_n,
    input  wire logic             indicator_out_b_in,
    output logic                  indicator_out_b_out,
    output logic                  indicator_out_b_oe_n
);

    initial begin
        if (ACT_W < 8 || TICK_DIV < 2) begin
            $error("sled_top: unsupported parameter values");
        end
    end

    // ****************************************************************
    // pin synchronisers and autosense
    // ****************************************************************
    logic [1:0] pin_a_s1_r;
    logic [1:0] pin_s2_r;
    logic       sense_done_r;
    logic [1:0] sensed_high_r;

    always_ff @(posedge ref_clk) begin
        pin_a_s1_r <= {indicator_out_b_in, indicator_out_a_in};
        pin_s2_r   <= pin_a_s1_r;
    end

    // pin held low at rest means the LED hangs to ground: drive high
    logic [1:0] sense_wait_r;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sense_done_r  <= 1'b0;
            sense_wait_r  <= 2'h0;
            sensed_high_r <= 2'h3;
        end else if (!sense_done_r) begin
            sense_wait_r <= sense_wait_r + 2'h1;
            if (sense_wait_r == 2'h3) begin
                sensed_high_r <= ~pin_s2_r;
                sense_done_r  <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [15:0] indicator_control_r;
    logic [3:0]  polarity_r;
    logic [1:0]  indicator_b_route_sel_r;
    logic [15:0] indicator_a_blink_time_r;
    logic [15:0] indicator_b_blink_time_r;

    logic        wr_pend_r;
    logic [11:0] wr_addr_r;
    logic        rd_req;
    logic        wr_req;

    assign rd_req = hsel & hready & htrans[1] & ~hwrite;
    assign wr_req = hsel & hready & htrans[1] & hwrite;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end else begin
            wr_pend_r <= wr_req;
            wr_addr_r <= haddr[11:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            indicator_control_r      <= sled_pkg::CONTROL_RST;
            polarity_r               <= {sled_pkg::POL_AUTO,
                                         sled_pkg::POL_AUTO};
            indicator_b_route_sel_r  <= sled_pkg::ROUTE_OFF;
            indicator_a_blink_time_r <= sled_pkg::BLINK_RST;
            indicator_b_blink_time_r <= sled_pkg::BLINK_RST;
        end else if (wr_pend_r) begin
            case (wr_addr_r)
                sled_pkg::OFS_CONTROL:  indicator_control_r <= hwdata[15:0];
                sled_pkg::OFS_POLARITY: polarity_r <= hwdata[3:0];
                sled_pkg::OFS_ROUTE:
                    indicator_b_route_sel_r <= hwdata[1:0];
                sled_pkg::OFS_BLINK_A:
                    indicator_a_blink_time_r <= hwdata[15:0];
                sled_pkg::OFS_BLINK_B:
                    indicator_b_blink_time_r <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // slow tick for blink timing
    // ****************************************************************
    logic [31:0] div_r;
    logic        tick_r;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            div_r  <= 32'h0;
            tick_r <= 1'b0;
        end else if (div_r == 32'(TICK_DIV - 1)) begin
            div_r  <= 32'h0;
            tick_r <= 1'b1;
        end else begin
            div_r  <= div_r + 32'h1;
            tick_r <= 1'b0;
        end
    end

    // ****************************************************************
    // polarity resolution
    // ****************************************************************
    function automatic logic resolve_high(input logic [1:0] pol,
                                          input logic sensed);
        case (pol)
            sled_pkg::POL_HIGH: resolve_high = 1'b1;
            sled_pkg::POL_LOW:  resolve_high = 1'b0;
            default:            resolve_high = sensed;
        endcase
    endfunction : resolve_high

    // ****************************************************************
    // channels
    // ****************************************************************
    logic [1:0] lit;
    logic [1:0] drive;
    logic [1:0] act_high;

    assign act_high[0] = resolve_high(polarity_r[1:0], sensed_high_r[0]);
    assign act_high[1] = resolve_high(polarity_r[3:2], sensed_high_r[1]);

    for (genvar g = 0; g < 2; g++) begin : g_chan
        localparam int S = g * sled_pkg::B_SHIFT;
        logic [15:0] bt;
        assign bt = g ? indicator_b_blink_time_r : indicator_a_blink_time_r;
        sled_blink #(.ACT_W(ACT_W)) u_chan (
            .ref_clk     (ref_clk),
            .reset       (reset),
            .tick        (tick_r),
            .enable      (indicator_control_r[S + sled_pkg::EN_BIT]),
            .blink_mode  (indicator_control_r[S + sled_pkg::MODE_BIT]),
            .func_sel    (indicator_control_r[S +: sled_pkg::FUNC_W]),
            .on_time     (bt[15:8]),
            .off_time    (bt[7:0]),
            .active_high (act_high[g]),
            .link_up     (link_up),
            .tx_act      (tx_act),
            .rx_act      (rx_act),
            .act_level   (act_level),
            .lit         (lit[g]),
            .drive       (drive[g])
        );
    end

    // ****************************************************************
    // pin drive
    // ****************************************************************
    logic b_routed;
    assign b_routed = indicator_b_route_sel_r == sled_pkg::ROUTE_ON;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            indicator_out_a_out  <= 1'b0;
            indicator_out_a_oe_n <= 1'b1;
            indicator_out_b_out  <= 1'b0;
            indicator_out_b_oe_n <= 1'b1;
        end else begin
            indicator_out_a_out  <= drive[0];
            indicator_out_a_oe_n <= ~sense_done_r;
            indicator_out_b_out  <= b_routed & drive[1];
            indicator_out_b_oe_n <= ~(sense_done_r & b_routed);
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (rd_req) begin
            case (haddr[11:0])
                sled_pkg::OFS_CONTROL:  hrdata <= {16'h0, indicator_control_r};
                sled_pkg::OFS_POLARITY: hrdata <= {28'h0, polarity_r};
                sled_pkg::OFS_ROUTE:
                    hrdata <= {30'h0, indicator_b_route_sel_r};
                sled_pkg::OFS_BLINK_A:
                    hrdata <= {16'h0, indicator_a_blink_time_r};
                sled_pkg::OFS_BLINK_B:
                    hrdata <= {16'h0, indicator_b_blink_time_r};
                sled_pkg::OFS_STATUS:
                    hrdata <= {27'h0, sense_done_r, act_high, lit};
                default: hrdata <= 32'h0;
            endcase
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_b_unrouted_off: assert property (@(posedge ref_clk) disable iff (reset)
        !b_routed |=> indicator_out_b_oe_n && !indicator_out_b_out)
        else $error("indicator b drives while not routed");

    chk_a_direct_pin: assert property (@(posedge ref_clk) disable iff (reset)
        sense_done_r |=> !indicator_out_a_oe_n)
        else $error("indicator a not driven");

    chk_reset_defaults: assert property (@(posedge ref_clk)
        $fell(reset) |-> indicator_control_r == sled_pkg::CONTROL_RST
            && polarity_r == 4'h0)
        else $error("reset defaults wrong");

    sequence s_sense_settle;
        $fell(reset) ##4 1'b1;
    endsequence
    chk_sense_latch: assert property (@(posedge ref_clk) disable iff (reset)
        s_sense_settle |=> sense_done_r)
        else $error("autosense did not complete");

    chk_sense_hold: assert property (@(posedge ref_clk) disable iff (reset)
        $past(sense_done_r) |-> $stable(sensed_high_r))
        else $error("autosense polarity changed while running");

    chk_high_pol: assert property (@(posedge ref_clk) disable iff (reset)
        act_high[0] && $stable(act_high[0]) |=>
            indicator_out_a_out == $past(lit[0]))
        else $error("active high drive mismatch");

    chk_low_pol: assert property (@(posedge ref_clk) disable iff (reset)
        !act_high[0] && $stable(act_high[0]) |=>
            indicator_out_a_out == !$past(lit[0]))
        else $error("active low drive mismatch");

    chk_disabled_dark: assert property (@(posedge ref_clk) disable iff (reset)
        !indicator_control_r[sled_pkg::EN_BIT] ##1
            !indicator_control_r[sled_pkg::EN_BIT] |-> !lit[0])
        else $error("disabled indicator lit");

endmodule : sled_top

// [status_led_driver_tb.sv]
// Purpose : self-checking bench for the status indicator driver
// Assumes : short tick divider, zero-wait bus slave
// Notes   : expectations come from bench functions and the shared package constants
`define SLED_CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("unexpected at %0t: got %0h want %0h", \
                     $time, got, exp); \
        end \
    end

module status_led_driver_tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int TDIV  = 4;
    localparam int LIMIT = 40000;

    logic        ref_clk, reset, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0]  htrans, seen;
    logic [2:0]  hsize;
    logic        link_up, tx_act, rx_act, lk, en, hi, m;
    logic [7:0]  act_level;
    logic [3:0]  f;
    logic        a_out, a_oe_n, b_out, b_oe_n, a_lvl, b_lvl;
    logic [3:0]  steady [3] = '{4'h2, 4'h5, 4'h6};
    int          n_errors, checks_done, cycles, seed, i, j, on, off;
    int          h0, l0, h1, l1;

    assign hready = hreadyout;

    sled_top #(.ACT_W(8), .TICK_DIV(TDIV)) dut (
        .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .link_up(link_up), .tx_act(tx_act),
        .rx_act(rx_act), .act_level(act_level),
        .indicator_out_a_in(a_lvl), .indicator_out_a_out(a_out),
        .indicator_out_a_oe_n(a_oe_n), .indicator_out_b_in(b_lvl),
        .indicator_out_b_out(b_out), .indicator_out_b_oe_n(b_oe_n));

    sled_led_model leds (
        .a_out(a_out), .a_oe_n(a_oe_n), .b_out(b_out), .b_oe_n(b_oe_n),
        .a_level(a_lvl), .b_level(b_lvl));

    // ****************************************************************
    // clock, timeout, verdict
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic complete_run;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_errors++;
            complete_run();
        end
    end

    // ****************************************************************
    // bus master and expectations
    // ****************************************************************
    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {20'h0, a};
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] x;
        bus(1'b1, a, wd, x);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] x);
        bus(1'b0, a, 32'h0, x);
    endtask : rd

    // lengths of one lit run and the following dark run on pin a
    task automatic measure(output int nh, output int nl);
        int k;
        nh = 0;
        nl = 0;
        for (k = 0; k < 3000 && a_out !== 1'b0; k++) @(posedge ref_clk);
        for (k = 0; k < 3000 && a_out !== 1'b1; k++) @(posedge ref_clk);
        while (a_out === 1'b1 && nh < 3000) begin
            nh++;
            @(posedge ref_clk);
        end
        while (a_out === 1'b0 && nl < 3000) begin
            nl++;
            @(posedge ref_clk);
        end
    endtask : measure

    function automatic logic [31:0] ctl(input logic [3:0] fa,
        input logic ma, input logic ea, input logic [3:0] fb,
        input logic mb, input logic eb);
        return {16'h0, eb, mb, 2'h0, fb, ea, ma, 2'h0, fa};
    endfunction : ctl

    function automatic logic pin_exp(input logic [3:0] fs, input logic e,
                                     input logic h, input logic l);
        logic lit;
        lit = e & ((fs == sled_pkg::FUNC_ALWAYS_ON) |
                   ((fs == sled_pkg::FUNC_LINK_ONLY) & l));
        return h ? lit : ~lit;
    endfunction : pin_exp

    function automatic logic [31:0] pol(input logic h);
        logic [1:0] p;
        p = h ? sled_pkg::POL_HIGH : sled_pkg::POL_LOW;
        return {28'h0, p, p};
    endfunction : pol

    // mode 2 lit length in ticks for an activity level
    function automatic int m2_on(input logic [7:0] lv);
        return (int'(lv) >> 1) + 1;
    endfunction : m2_on

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        seed = 32'h54974F0E;
        {hsel, hwrite, link_up, tx_act, rx_act} = 5'h00;
        {haddr, hwdata} = 64'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        act_level = 8'h00;
        reset = 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        for (j = 0; j < 2; j++) begin
            repeat (10) @(posedge ref_clk);
            rd(sled_pkg::OFS_CONTROL, d);
            `SLED_CHK(d, {16'h0, sled_pkg::CONTROL_RST})
            rd(sled_pkg::OFS_POLARITY, d);
            `SLED_CHK(d, 32'h0)
            rd(sled_pkg::OFS_ROUTE, d);
            `SLED_CHK(d, 32'h0)
            rd(sled_pkg::OFS_BLINK_A, d);
            `SLED_CHK(d, {16'h0, sled_pkg::BLINK_RST})
            // autosense: a rests high, b rests low
            rd(sled_pkg::OFS_STATUS, d);
            `SLED_CHK(d[4:2], 3'b110)
            `SLED_CHK({a_oe_n, b_oe_n}, 2'b01)
            rd(12'h040, d);
            `SLED_CHK(d, 32'h0)
            if (j == 1) complete_run();
            // steady functions with random inputs, both polarities
            wr(sled_pkg::OFS_ROUTE, {30'h0, sled_pkg::ROUTE_ON});
            for (i = 0; i < 24; i++) begin
                f  = steady[$unsigned($random(seed)) % 3];
                en = (i < 3) ? 1'b0 : 1'($random(seed));
                hi = 1'($random(seed));
                lk = 1'($random(seed));
                link_up   <= lk;
                tx_act    <= 1'($random(seed));
                rx_act    <= 1'($random(seed));
                act_level <= 8'($random(seed));
                wr(sled_pkg::OFS_POLARITY, pol(hi));
                wr(sled_pkg::OFS_CONTROL, ctl(f, 1'b0, en, f, 1'b0, en));
                repeat (4) @(posedge ref_clk);
                #1;
                `SLED_CHK(a_out, pin_exp(f, en, hi, lk))
                `SLED_CHK({b_oe_n, b_out}, {1'b0, pin_exp(f, en, hi, lk)})
            end
            // free-running codes blink in mode 1 and stay dark in mode 2
            wr(sled_pkg::OFS_POLARITY, pol(1'b1));
            for (i = 7; i <= 10; i++) begin
                for (m = 0; m <= 1; m++) begin
                    wr(sled_pkg::OFS_CONTROL,
                       ctl(4'(i), m, 1'b1, 4'h6, 1'b0, 1'b0));
                    // let the old pattern drain out of the pin pipeline
                    repeat (4) @(posedge ref_clk);
                    seen = 2'b00;
                    repeat (200) begin
                        @(negedge ref_clk);
                        seen[a_out] = 1'b1;
                    end
                    `SLED_CHK(seen, m ? 2'b01 : 2'b11)
                    if (m) break;
                end
            end
            // mode 1 on/off times, boundary then random
            wr(sled_pkg::OFS_CONTROL,
               ctl(4'h7, 1'b0, 1'b1, 4'h6, 1'b0, 1'b0));
            for (i = 0; i < 3; i++) begin
                on  = (i == 0) ? 1 : 1 + $unsigned($random(seed)) % 8;
                off = (i == 0) ? 1 : 1 + $unsigned($random(seed)) % 8;
                wr(sled_pkg::OFS_BLINK_A, {16'h0, 8'(on), 8'(off)});
                measure(h0, l0);
                measure(h0, l0);
                `SLED_CHK(h0, on * TDIV)
                `SLED_CHK(l0, off * TDIV)
            end
            // mode 2: traffic on, duty follows activity level
            tx_act <= 1'b1;
            act_level <= 8'h00;
            wr(sled_pkg::OFS_CONTROL,
               ctl(4'h1, 1'b1, 1'b1, 4'h6, 1'b0, 1'b0));
            measure(h0, l0);
            measure(h0, l0);
            act_level <= 8'hFF;
            measure(h1, l1);
            measure(h1, l1);
            `SLED_CHK(h1 > h0 && l1 < l0 && h0 > 0, 1'b1)
            `SLED_CHK(h0, m2_on(8'h00) * TDIV)
            `SLED_CHK(l0, (129 - m2_on(8'h00)) * TDIV)
            `SLED_CHK(h1, m2_on(8'hFF) * TDIV)
            `SLED_CHK(l1, (129 - m2_on(8'hFF)) * TDIV)
            reset <= 1'b1;
            repeat (2) @(posedge ref_clk);
            reset <= 1'b0;
        end
    end

endmodule : status_led_driver_tb
